// ===== hdl/sfr_space_pkg.sv
package sfr_space_pkg;

  localparam int          DATA_W        = 8;
  localparam int          NUM_REGS      = 28;
  localparam int          IDX_W         = 5;

  // Direct byte addresses with this bit set fall in the register space
  localparam int          UPPER_BIT     = 7;
  localparam logic [3:0]  BIT_NIB_LO    = 4'h0;
  localparam logic [3:0]  BIT_NIB_HI    = 4'h8;
  localparam logic [7:0]  RAM_BIT_BASE  = 8'h20;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;

  // Fields of a bit address and of a register address
  localparam int          BIT_POS_W     = 3;
  localparam int          RAM_SEL_HI    = 6;
  localparam int          NIB_W         = 4;

  localparam logic [7:0] ADDR_CLOCK_PRESCALE_CONTROL = 8'h8e;
  localparam logic [7:0] ADDR_CAP_THRESHOLD_LOW      = 8'h96;
  localparam logic [7:0] ADDR_CAP_THRESHOLD_HIGH     = 8'h97;
  localparam logic [7:0] ADDR_COMPARATOR_CONTROL     = 8'h9b;
  localparam logic [7:0] ADDR_COMPARATOR_MODE_SELECT = 8'h9d;
  localparam logic [7:0] ADDR_COMPARATOR_INPUT_SEL   = 8'h9f;
  localparam logic [7:0] ADDR_SYSTEM_CLOCK_SELECT    = 8'ha9;
  localparam logic [7:0] ADDR_CAP_RESULT_LOW         = 8'hab;
  localparam logic [7:0] ADDR_CAP_RESULT_HIGH        = 8'hac;
  localparam logic [7:0] ADDR_CAP_SENSE_CONTROL      = 8'hb0;
  localparam logic [7:0] ADDR_SILICON_REVISION_ID    = 8'hb6;
  localparam logic [7:0] ADDR_ANALOG_MUX_CHANNEL_SEL = 8'hbb;
  localparam logic [7:0] ADDR_ADC_CONFIGURATION      = 8'hbc;
  localparam logic [7:0] ADDR_ADC_RESULT_LOW         = 8'hbd;
  localparam logic [7:0] ADDR_ADC_RESULT_HIGH        = 8'hbe;
  localparam logic [7:0] ADDR_ADC_WINDOW_ABOVE_LOW   = 8'hc3;
  localparam logic [7:0] ADDR_ADC_WINDOW_ABOVE_HIGH  = 8'hc4;
  localparam logic [7:0] ADDR_ADC_WINDOW_BELOW_LOW   = 8'hc5;
  localparam logic [7:0] ADDR_ADC_WINDOW_BELOW_HIGH  = 8'hc6;
  localparam logic [7:0] ADDR_CHECKSUM_CONTROL       = 8'hce;
  localparam logic [7:0] ADDR_CHECKSUM_BIT_REVERSE   = 8'hcf;
  localparam logic [7:0] ADDR_CHECKSUM_AUTO_CONTROL  = 8'hd2;
  localparam logic [7:0] ADDR_CHECKSUM_SECTOR_COUNT  = 8'hd3;
  localparam logic [7:0] ADDR_CHECKSUM_INPUT         = 8'hdd;
  localparam logic [7:0] ADDR_CHECKSUM_OUTPUT        = 8'hde;
  localparam logic [7:0] ADDR_ACCUMULATOR            = 8'he0;
  localparam logic [7:0] ADDR_ADC_CONTROL            = 8'he8;
  localparam logic [7:0] ADDR_MULTIPLY_OPERAND       = 8'hf0;

  localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
    ADDR_CLOCK_PRESCALE_CONTROL, ADDR_CAP_THRESHOLD_LOW, ADDR_CAP_THRESHOLD_HIGH,
    ADDR_COMPARATOR_CONTROL, ADDR_COMPARATOR_MODE_SELECT, ADDR_COMPARATOR_INPUT_SEL,
    ADDR_SYSTEM_CLOCK_SELECT, ADDR_CAP_RESULT_LOW, ADDR_CAP_RESULT_HIGH,
    ADDR_CAP_SENSE_CONTROL, ADDR_SILICON_REVISION_ID, ADDR_ANALOG_MUX_CHANNEL_SEL,
    ADDR_ADC_CONFIGURATION, ADDR_ADC_RESULT_LOW, ADDR_ADC_RESULT_HIGH,
    ADDR_ADC_WINDOW_ABOVE_LOW, ADDR_ADC_WINDOW_ABOVE_HIGH, ADDR_ADC_WINDOW_BELOW_LOW,
    ADDR_ADC_WINDOW_BELOW_HIGH, ADDR_CHECKSUM_CONTROL, ADDR_CHECKSUM_BIT_REVERSE,
    ADDR_CHECKSUM_AUTO_CONTROL, ADDR_CHECKSUM_SECTOR_COUNT, ADDR_CHECKSUM_INPUT,
    ADDR_CHECKSUM_OUTPUT, ADDR_ACCUMULATOR, ADDR_ADC_CONTROL, ADDR_MULTIPLY_OPERAND
  };

  localparam logic [IDX_W-1:0] IDX_REVISION   = 5'h0a;
  localparam logic [IDX_W-1:0] IDX_AUTO_CTRL  = 5'h15;
  localparam logic [IDX_W-1:0] IDX_SECTOR_CNT = 5'h16;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       indirect;
    logic       is_bit;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wbit;
  } sfr_req_s;

  typedef struct packed {
    logic       valid;
    logic       to_sfr;
    logic       to_ram;
    logic       hit;
    logic       read_only;
    logic [7:0] rdata;
    logic       rbit;
  } sfr_resp_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       is_bit;
    logic [2:0] bit_pos;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wbit;
  } ram_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } per_wr_s;

  typedef struct packed {
    logic             hit;
    logic [IDX_W-1:0] idx;
  } reg_hit_s;

endpackage

// ===== hdl/sfr_space_decoder.sv
`timescale 1ns/1ps

module sfr_space_decoder
  import sfr_space_pkg::*;
#(
  // Arbitrary value; set per fabricated revision
  parameter logic [7:0] REVISION_ID = 8'h5a
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire sfr_req_s   core_req,
  output sfr_resp_s       core_resp,
  output ram_req_s        ram_req,
  output per_wr_s         per_wr,
  output logic [7:0]      checksum_auto_control,
  output logic [7:0]      checksum_sector_count
);

  function automatic reg_hit_s find_reg(input logic [7:0] a);
    reg_hit_s r;
    r = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_ADDR[i] == a) begin
        r.hit = 1'b1;
        r.idx = IDX_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic bit_capable(input logic [7:0] a);
    return (a[NIB_W-1:0] == BIT_NIB_LO) || (a[NIB_W-1:0] == BIT_NIB_HI);
  endfunction

  // Bit address to the byte that holds it
  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    if (b[UPPER_BIT]) begin
      r = {b[DATA_W-1:BIT_POS_W], {BIT_POS_W{1'b0}}};
    end else begin
      r = RAM_BIT_BASE + 8'(b[RAM_SEL_HI:BIT_POS_W]);
    end
    return r;
  endfunction

  // Decoded view of the request on the current cycle
  logic [7:0]           byte_addr;
  logic [BIT_POS_W-1:0] bit_pos;
  logic                 sfr_path;
  logic                 take_sfr;
  logic                 take_ram;
  reg_hit_s             lookup;
  logic                 reg_hit;
  logic                 rev_hit;
  logic                 slot_we;
  logic [7:0]           cur_val;
  logic [7:0]           new_val;

  // Register slots, one flop byte each
  wire logic [7:0]      slot_q [NUM_REGS];

  // Registered outputs, one group each
  sfr_resp_s            resp_r;
  sfr_resp_s            resp_nxt;
  ram_req_s             ram_r;
  ram_req_s             ram_nxt;
  per_wr_s              per_r;
  per_wr_s              per_nxt;

  // Request decode: pure logic shared by every group below
  always_comb begin
    byte_addr = core_req.addr;
    bit_pos   = core_req.addr[BIT_POS_W-1:0];
    if (core_req.is_bit) begin
      byte_addr = bit_byte(core_req.addr);
    end
    // Bit operands are always direct, so an indirect flag on them is ignored
    sfr_path = (core_req.is_bit || !core_req.indirect) && byte_addr[UPPER_BIT];
    take_sfr = core_req.valid && sfr_path;
    take_ram = core_req.valid && !sfr_path;
    lookup   = find_reg(byte_addr);
    reg_hit  = 1'b0;
    if (take_sfr && lookup.hit) begin
      reg_hit = 1'b1;
    end
    // A bit address above the lower half always names a nibble 0/8 byte,
    // so this guard only matters if the bit encoding is ever widened
    if (core_req.is_bit && !bit_capable(byte_addr)) begin
      reg_hit = 1'b0;
    end
    rev_hit = reg_hit && (lookup.idx == IDX_REVISION);
    cur_val = UNMAPPED_READ;
    if (reg_hit) begin
      cur_val = slot_q[lookup.idx];
    end
    new_val = core_req.wdata;
    if (core_req.is_bit) begin
      new_val          = cur_val;
      new_val[bit_pos] = core_req.wbit;
    end
    // The revision byte and unassigned places never take a write
    slot_we = reg_hit && core_req.write && !rev_hit;
  end

  // One storage slot per listed register. The revision slot keeps its reset
  // value for ever, since the decode never raises the write strobe for it.
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_slot
    localparam logic [7:0] SLOT_INIT = (g == int'(IDX_REVISION)) ? REVISION_ID : REG_RESET;
    logic [7:0]            slot_r;
    logic [7:0]            slot_nxt;

    always_comb begin
      slot_nxt = slot_r;
      if (slot_we && (lookup.idx == IDX_W'(g))) begin
        slot_nxt = new_val;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        slot_r <= SLOT_INIT;
      end else begin
        slot_r <= slot_nxt;
      end
    end

    assign slot_q[g] = slot_r;
  end

  // Response to the core, one cycle after the request
  always_comb begin
    resp_nxt = '0;
    if (core_req.valid) begin
      resp_nxt.valid = 1'b1;
    end
    if (take_sfr) begin
      resp_nxt.to_sfr    = 1'b1;
      resp_nxt.hit       = reg_hit;
      resp_nxt.read_only = rev_hit;
      // Old value, so a read-modify-write in the core sees what it replaced
      resp_nxt.rdata     = cur_val;
      resp_nxt.rbit      = cur_val[bit_pos];
    end
    if (take_ram) begin
      resp_nxt.to_ram = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resp_r <= '0;
    end else begin
      resp_r <= resp_nxt;
    end
  end

  // Everything that misses the register space is passed on to the RAM side
  always_comb begin
    ram_nxt = '0;
    if (take_ram) begin
      ram_nxt.valid   = 1'b1;
      ram_nxt.write   = core_req.write;
      ram_nxt.is_bit  = core_req.is_bit;
      ram_nxt.bit_pos = bit_pos;
      ram_nxt.addr    = byte_addr;
      ram_nxt.wdata   = core_req.wdata;
      ram_nxt.wbit    = core_req.wbit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ram_r <= '0;
    end else begin
      ram_r <= ram_nxt;
    end
  end

  // Write notice for the peripheral behind each register; bit writes carry
  // the merged byte, so the peripheral never has to merge on its own
  always_comb begin
    per_nxt = '0;
    if (slot_we) begin
      per_nxt.valid = 1'b1;
      per_nxt.addr  = byte_addr;
      per_nxt.data  = new_val;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      per_r <= '0;
    end else begin
      per_r <= per_nxt;
    end
  end

  assign core_resp             = resp_r;
  assign ram_req               = ram_r;
  assign per_wr                = per_r;
  assign checksum_auto_control = slot_q[IDX_AUTO_CTRL];
  assign checksum_sector_count = slot_q[IDX_SECTOR_CNT];

endmodule // sfr_space_decoder

// ===== verification/sfr_space_decoder_chk.sv
`timescale 1ns/1ps
module sfr_space_decoder_chk
  import sfr_space_pkg::*;
#(parameter logic [7:0] REVISION_ID = 8'h5a) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire sfr_req_s   core_req,
  input wire sfr_resp_s  core_resp,
  input wire ram_req_s   ram_req,
  input wire per_wr_s    per_wr,
  input wire logic [7:0] checksum_auto_control,
  input wire logic [7:0] checksum_sector_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire       dir = core_req.valid && !core_req.indirect;
  wire [7:0] a   = core_req.addr;
  sfr_req_s  prev_r;
  always_ff @(posedge sys_clk) begin
    prev_r <= core_req;
  end
  sequence s_byte_wr(logic [7:0] x);
    dir && core_req.write && !core_req.is_bit && a == x;
  endsequence
  a_direct_sfr: assert property (dir && a[7] |=> core_resp.to_sfr && !ram_req.valid)
    else $error("direct access missed registers");
  a_bit_merge: assert property (dir && core_req.is_bit && core_req.write && a[7] |=>
    !per_wr.valid || per_wr.data[prev_r.addr[2:0]] == prev_r.wbit) else $error("bit not merged");
  a_bit_byte: assert property (per_wr.valid && prev_r.is_bit |-> per_wr.addr[2:0] == 3'h0)
    else $error("bit write on byte-only place");
  a_rev_ro: assert property (s_byte_wr(ADDR_SILICON_REVISION_ID) |=>
    core_resp.read_only && !per_wr.valid && core_resp.rdata == REVISION_ID) else $error("revision written");
  a_auto_ctrl: assert property (s_byte_wr(ADDR_CHECKSUM_AUTO_CONTROL) |=>
    checksum_auto_control == prev_r.wdata) else $error("auto control lost");
  a_sector_cnt: assert property (s_byte_wr(ADDR_CHECKSUM_SECTOR_COUNT) |=>
    checksum_sector_count == prev_r.wdata) else $error("sector count lost");
  a_indirect_ram: assert property (core_req.valid && core_req.indirect && !core_req.is_bit && a[7] |=>
    ram_req.valid && ram_req.addr == prev_r.addr && !core_resp.to_sfr) else $error("indirect not to ram");
  a_unmapped_zero: assert property (core_resp.valid && core_resp.to_sfr && !core_resp.hit |->
    core_resp.rdata == 8'h00 && !per_wr.valid) else $error("reserved place not silent");
endmodule // sfr_space_decoder_chk
bind sfr_space_decoder sfr_space_decoder_chk #(.REVISION_ID(REVISION_ID)) u_chk (.sys_clk, .rst, .core_req,
  .core_resp, .ram_req, .per_wr, .checksum_auto_control, .checksum_sector_count);

// ===== verification/core_model.sv
`timescale 1ns/1ps
module core_model
  import sfr_space_pkg::*;
(
  input wire logic sys_clk,
  output sfr_req_s core_req
);
  initial core_req = '0;
  // Reserved places only when a test probes them on purpose
  task automatic issue(input logic w, i, b, input logic [7:0] ad, wd, input logic wb);
    @(posedge sys_clk);
    core_req <= '{1'b1, w, i, b, ad, wd, wb};
    @(posedge sys_clk);
    core_req <= '0;
  endtask
endmodule // core_model

// ===== verification/sfr_space_decoder_tb.sv
`timescale 1ns/1ps
module sfr_space_decoder_tb
  import sfr_space_pkg::*;
;
  localparam logic [7:0] REV = 8'h5a; // Arbitrary revision value
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  int         mismatches = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  sfr_req_s   core_req;
  sfr_resp_s  core_resp;
  ram_req_s   ram_req;
  per_wr_s    per_wr;
  logic [7:0] auto_ctl;
  logic [7:0] sec_cnt;
  logic [7:0] d;
  logic [7:0] probe [3] = '{8'hb5, 8'had, 8'h84};
  always #2.5 sys_clk = ~sys_clk;
  core_model u_core (.sys_clk, .core_req);
  sfr_space_decoder #(.REVISION_ID(REV)) uut (.sys_clk, .rst, .core_req, .core_resp, .ram_req, .per_wr,
    .checksum_auto_control(auto_ctl), .checksum_sector_count(sec_cnt));
  task automatic chk(string n, logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  // Response is registered at the edge that drops the request
  task automatic acc(logic w, i, b, logic [7:0] ad, wd, logic wb);
    u_core.issue(w, i, b, ad, wd, wb);
    #1;
  endtask
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      d = REG_ADDR[i] ^ 8'h3c;
      acc(0, 0, 0, REG_ADDR[i], 0, 0);
      chk("reset value", core_resp.rdata, (i == IDX_REVISION) ? REV : REG_RESET);
      acc(1, 0, 0, REG_ADDR[i], d, 0);
      chk("write route", {core_resp.valid, core_resp.to_sfr, core_resp.hit, per_wr.valid},
        {3'h7, i != IDX_REVISION});
      chk("write notice", {per_wr.addr, per_wr.data}, (i == IDX_REVISION) ? 16'h0 : {REG_ADDR[i], d});
      chk("write read only", core_resp.read_only, i == IDX_REVISION);
      acc(0, 0, 0, REG_ADDR[i], 0, 0);
      chk("read back", core_resp.rdata, (i == IDX_REVISION) ? REV : d);
    end
    chk("auto control", auto_ctl, 8'hd2 ^ 8'h3c);
    chk("sector count", sec_cnt, 8'hd3 ^ 8'h3c);
    acc(1, 0, 1, 8'he5, 0, 1);
    chk("bit write", {per_wr.addr, per_wr.data}, 16'he0fc);
    acc(0, 0, 1, 8'he5, 0, 0);
    chk("bit read", core_resp.rbit, 1);
    acc(0, 1, 1, 8'he5, 0, 0);
    chk("bit ignores indirect", {core_resp.to_sfr, core_resp.rbit}, 2'h3);
    acc(1, 1, 0, 8'h90, 8'h77, 0);
    chk("indirect route", {ram_req.valid, core_resp.to_ram, core_resp.to_sfr}, 3'h6);
    chk("indirect addr", ram_req.addr, 8'h90);
    chk("indirect data", {ram_req.write, ram_req.is_bit, ram_req.wdata}, {2'h2, 8'h77});
    acc(1, 1, 0, 8'he0, 8'h11, 0);
    chk("indirect no notice", {per_wr.valid, ram_req.valid}, 2'h1);
    acc(0, 0, 0, 8'he0, 0, 0);
    chk("shadowed register", core_resp.rdata, 8'hfc);
    acc(0, 0, 0, 8'h40, 0, 0);
    chk("direct low route", {ram_req.valid, core_resp.to_ram, core_resp.to_sfr, ram_req.addr},
      {3'h6, 8'h40});
    acc(1, 0, 1, 8'h13, 0, 1);
    chk("ram bit", {ram_req.valid, ram_req.is_bit, ram_req.bit_pos, ram_req.addr, ram_req.wbit},
      {2'h3, 3'h3, 8'h22, 1'h1});
    for (int j = 0; j < 3; j++) begin
      acc(1, 0, 0, probe[j], 8'hff, 0);
      chk("reserved write", per_wr.valid, 0);
      acc(0, 0, 0, probe[j], 0, 0);
      chk("reserved read", {core_resp.hit, core_resp.rdata}, 0);
    end
    complete_run();
  end
endmodule // sfr_space_decoder_tb
